// [shared/hvsp_pkg.sv]
// Constants shared by the horizontal/vertical sync processor.
// Assumes a 125 MHz system clock from which the 8/12 MHz time base is derived.
package hvsp_pkg;

  // ----------------------------------------------------------------
  // Clocking and time base
  // ----------------------------------------------------------------
  localparam logic [7:0] CLOCK_MHZ    = 8'h7d;  // 125 MHz system clock.
  localparam logic [7:0] OSC_SLOW_MHZ = 8'h08;  // Time base with select low.
  localparam logic [7:0] OSC_FAST_MHZ = 8'h0c;  // Time base with select high.
  localparam int OSC_SLOW_HZ = 8_000_000;
  localparam int OSC_FAST_HZ = 12_000_000;

  // ----------------------------------------------------------------
  // Presence, extraction and blanking thresholds
  // ----------------------------------------------------------------
  localparam int H_SET_HZ        = 10_000;  // Horizontal present above this.
  localparam int V_SET_HZ        = 40;      // Vertical present above this.
  localparam int PRES_CLR_HZ     = 10;      // Any present flag drops below this.
  localparam int VB_MAX_HZ_SLOW  = 200;     // Blanking cut-off, slow base.
  localparam int VB_MAX_HZ_FAST  = 133;     // Blanking cut-off, fast base.
  localparam int CV_DELAY_US     = 10;      // Broad pulse length for extraction.
  localparam int H_SET_SLOW   = OSC_SLOW_HZ / H_SET_HZ;
  localparam int H_SET_FAST   = OSC_FAST_HZ / H_SET_HZ;
  localparam int V_SET_SLOW   = OSC_SLOW_HZ / V_SET_HZ;
  localparam int V_SET_FAST   = OSC_FAST_HZ / V_SET_HZ;
  localparam int CLR_SLOW     = OSC_SLOW_HZ / PRES_CLR_HZ;
  localparam int CLR_FAST     = OSC_FAST_HZ / PRES_CLR_HZ;
  localparam int CV_SLOW      = CV_DELAY_US * (OSC_SLOW_HZ / 1_000_000);
  localparam int CV_FAST      = CV_DELAY_US * (OSC_FAST_HZ / 1_000_000);

  // ----------------------------------------------------------------
  // Counter geometry
  // ----------------------------------------------------------------
  localparam int PRES_W    = 21;  // Presence and polarity tick counters.
  localparam int HORIZ_COUNT_LATCH_W    = 15;  // Horizontal period counter.
  localparam int HLATCH_W  = 11;  // Horizontal result width.
  localparam int VERT_COUNT_LATCH_W    = 14;  // Vertical period counter.
  localparam int VLATCH_W  = 9;   // Vertical result width.
  localparam logic [5:0] H_WINDOW_LAST = 6'h3f;  // 64 horizontal periods.
  localparam logic [3:0] V_PRESCALE_LAST = 4'hf; // 16 ticks per count.
  localparam int VB_SLOW_CNT = OSC_SLOW_HZ / VB_MAX_HZ_SLOW / 16;
  localparam int VB_FAST_CNT = OSC_FAST_HZ / VB_MAX_HZ_FAST / 16;

  // ----------------------------------------------------------------
  // Event flag positions and source select codes
  // ----------------------------------------------------------------
  localparam int FLG_HPR = 5;
  localparam int FLG_VPR = 4;
  localparam int FLG_HPL = 3;
  localparam int FLG_VPL = 2;
  localparam int FLG_HF  = 1;
  localparam int FLG_VF  = 0;
  localparam logic [1:0] SRC_OFF  = 2'h0;  // Composite disabled.
  localparam logic [1:0] SRC_AUTO = 2'h1;  // Automatic switch-over.
  localparam logic [1:0] SRC_VIN  = 2'h2;  // Direct vertical input.
  localparam logic [1:0] SRC_CV   = 2'h3;  // Extracted vertical sync.

endpackage

// [logic/hvsp_top.sv]
// Horizontal/vertical sync processor: separation, presence, period and polarity.
// Assumes sync pins are asynchronous and software clears flags by one-cycle pulses.
//
// Operation
// R1: Pulses shorter than one oscillator period ignored.
// R2: Extract vertical from horizontal, flag its presence.
// R3: Software may select extracted vertical as source.
// R4: Extracted vertical lags composite by 10-16 us.
// R5: 15-bit counter times 64 horizontal periods.
// R6: Horizontal result refreshes per frame or continuously.
// R7: 14-bit counter times vertical period, 9 bits.
// R8: Vertical result in 512-tick units, every frame.
// R9: Each counter reports its own overflow.
// R10: Frequency event on count change or overflow.
// R11: Counts within one LSB of ideal.
// R12: Horizontal presence: set 10 kHz, clear 10 Hz.
// R13: Vertical presence: set 40 Hz, clear 10 Hz.
// R14: Time-base select sets presence reference timing.
// R15: Horizontal presence change raises its event flag.
// R16: Vertical or composite presence change raises event.
// R17: High longer than low means negative polarity.
// R18: Polarity changes raise horizontal/vertical event flags.
// R19: Protect blank output against fast vertical sync.
// R20: Select low is 8 MHz, high 12 MHz.
// R21: Blank cut above 200 Hz or 133 Hz.
// R22: Source select field: 11, 10, 00, 01.
// R23: Software clears pending flags when servicing interrupt.
// R24: Presence flags hold between thresholds (hysteresis).
`timescale 1ns/1ps
`default_nettype none

module hvsp_top
  import hvsp_pkg::*;
#(
  parameter int V_SET_SLOW_P = V_SET_SLOW,  // Vertical set period, slow base.
  parameter int V_SET_FAST_P = V_SET_FAST,  // Vertical set period, fast base.
  parameter int CLR_SLOW_P   = CLR_SLOW,    // Presence drop period, slow base.
  parameter int CLR_FAST_P   = CLR_FAST,    // Presence drop period, fast base.
  parameter int VB_SLOW_P    = VB_SLOW_CNT, // Blank cut-off in vertical counts.
  parameter int VB_FAST_P    = VB_FAST_CNT
)(
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic                clk_en,
  input  wire logic                hsync_in,
  input  wire logic                vsync_in,
  input  wire logic [1:0]          sync_source_select,
  input  wire logic                presence_timebase_select,
  input  wire logic [5:0]          flag_clear,
  output logic                     composite_vert_present,
  output logic                     horiz_present,
  output logic                     vert_present,
  output logic                     horiz_polarity,
  output logic                     vert_polarity,
  output logic [HLATCH_W-1:0]      horiz_count_latch,
  output logic                     horiz_overflow,
  output logic [VLATCH_W-1:0]      vert_count_latch,
  output logic                     vert_overflow,
  output logic                     vert_blank_out,
  output logic                     horiz_presence_change_flag,
  output logic                     vert_presence_change_flag,
  output logic                     horiz_polarity_change_flag,
  output logic                     vert_polarity_change_flag,
  output logic                     horiz_freq_change_flag,
  output logic                     vert_freq_change_flag
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;   // Reset release pipeline.
  logic       rst_n;          // Internal synchronised reset.
  logic [1:0] pin_meta_reg;   // First stage, read only by second stage.
  logic [1:0] pin_sync_reg;   // Second stage: {vsync, hsync}.

  // Reset asserts at once but releases two edges later.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b) rst_sync_reg <= 2'h0;
    else        rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // Sync pins come from another source and must be retimed first.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
    end
    else if (clk_en)
    begin
      pin_meta_reg <= {vsync_in, hsync_in};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator time base
  // ----------------------------------------------------------------
  logic [7:0] osc_acc_reg;  // Fractional phase accumulator.
  logic [7:0] osc_sum;      // Accumulator plus step.
  logic       osc_tick;     // One system cycle per oscillator period.
  logic       half_reg;     // Alternates every oscillator tick.

  assign osc_sum  = osc_acc_reg + (presence_timebase_select ? OSC_FAST_MHZ : OSC_SLOW_MHZ); // R20
  assign osc_tick = osc_sum >= CLOCK_MHZ;

  // A phase accumulator gives the exact mean rate with some tick jitter.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_acc_reg <= 8'h00;
      half_reg    <= 1'b0;
    end
    else if (clk_en)
    begin
      osc_acc_reg <= osc_tick ? osc_sum - CLOCK_MHZ : osc_sum; // R14
      if (osc_tick) half_reg <= ~half_reg;
    end
  end

  // ----------------------------------------------------------------
  // Noise filter: a level must be seen at two ticks in a row
  // ----------------------------------------------------------------
  logic [1:0] samp_reg;  // Level seen at the previous tick.
  logic [1:0] filt_reg;  // Filtered {vsync, hsync}.

  for (genvar i = 0; i < 2; i++)
  begin : g_filt
    always_ff @(posedge clock or negedge rst_n)
    begin
      if (!rst_n)
      begin
        samp_reg[i] <= 1'b0;
        filt_reg[i] <= 1'b0;
      end
      else if (clk_en && osc_tick)
      begin
        samp_reg[i] <= pin_sync_reg[i];
        if (samp_reg[i] == pin_sync_reg[i]) filt_reg[i] <= pin_sync_reg[i]; // R1
      end
    end
  end

  // ----------------------------------------------------------------
  // Composite separation
  // ----------------------------------------------------------------
  logic [7:0] cv_run_reg;  // Length of the current active horizontal pulse.
  logic       cv_reg;      // Extracted vertical sync, active high.
  logic       h_active;    // Horizontal input at its active level.
  logic [7:0] cv_limit;    // Broad pulse threshold in ticks.
  logic [2:0] pres_reg;    // Present flags {cv, v, h}.
  logic [1:0] pol_reg;     // Polarities {v, h}, one is positive.

  assign h_active = ~(filt_reg[0] ^ pol_reg[0]);
  assign cv_limit = presence_timebase_select ? 8'(CV_FAST) : 8'(CV_SLOW);

  // A broad pulse asserts extracted sync once it has lasted the threshold,
  // so the lag stays 10 us on either time base; a normal short pulse ends it.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cv_run_reg <= 8'h00;
      cv_reg     <= 1'b0;
    end
    else if (clk_en && osc_tick)
    begin
      if (h_active)
      begin
        if (cv_run_reg < cv_limit) cv_run_reg <= cv_run_reg + 8'h01;
        if (cv_run_reg == cv_limit - 8'h01) cv_reg <= 1'b1; // R2 R4
      end
      else
      begin
        if (cv_run_reg != 8'h00 && cv_run_reg < cv_limit) cv_reg <= 1'b0;
        cv_run_reg <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Vertical source selection
  // ----------------------------------------------------------------
  logic sel_v;  // Vertical sync used for polarity, period and blanking.

  always_comb
  begin
    unique case (sync_source_select)
      SRC_CV:   sel_v = cv_reg; // R3 R22
      SRC_AUTO: sel_v = (pres_reg[2] && !pres_reg[1]) ? cv_reg : filt_reg[1]; // R22
      SRC_VIN:  sel_v = filt_reg[1];
      SRC_OFF:  sel_v = filt_reg[1];
    endcase
  end

  // ----------------------------------------------------------------
  // Presence check on {cv, v, h}
  // ----------------------------------------------------------------
  logic [2:0]        pres_sig;       // Signals checked.
  logic [2:0]        pres_prev_reg;  // Level at previous tick.
  logic [2:0]        pres_d_reg;     // Flags one cycle ago.
  logic [PRES_W-1:0] pres_cnt_reg [3];
  logic [PRES_W-1:0] set_lim [3];
  logic [PRES_W-1:0] clr_lim;

  assign pres_sig = {cv_reg, filt_reg[1], filt_reg[0]};
  assign set_lim[0] = presence_timebase_select ? PRES_W'(H_SET_FAST) : PRES_W'(H_SET_SLOW);
  assign set_lim[1] = presence_timebase_select ? PRES_W'(V_SET_FAST_P) : PRES_W'(V_SET_SLOW_P);
  assign set_lim[2] = set_lim[1];
  assign clr_lim    = presence_timebase_select ? PRES_W'(CLR_FAST_P) : PRES_W'(CLR_SLOW_P);

  for (genvar k = 0; k < 3; k++)
  begin : g_pres
    // Short periods set the flag, a long silence clears it, else it holds.
    always_ff @(posedge clock or negedge rst_n)
    begin
      if (!rst_n)
      begin
        pres_prev_reg[k] <= 1'b0;
        pres_cnt_reg[k]  <= '0;
        pres_reg[k]      <= 1'b0;
        pres_d_reg[k]    <= 1'b0;
      end
      else if (clk_en)
      begin
        pres_d_reg[k] <= pres_reg[k];
        if (osc_tick)
        begin
          pres_prev_reg[k] <= pres_sig[k];
          if (pres_sig[k] && !pres_prev_reg[k])
          begin
            if (pres_cnt_reg[k] < set_lim[k]) pres_reg[k] <= 1'b1; // R12 R13 R24
            pres_cnt_reg[k] <= '0;
          end
          else if (pres_cnt_reg[k] >= clr_lim) pres_reg[k] <= 1'b0; // R12 R13
          else pres_cnt_reg[k] <= pres_cnt_reg[k] + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Polarity detection on {selected v, h}
  // ----------------------------------------------------------------
  logic [1:0]        pol_sig;
  logic [1:0]        pol_prev_reg;
  logic [1:0]        pol_d_reg;
  logic [PRES_W-1:0] hi_cnt_reg [2];
  logic [PRES_W-1:0] lo_cnt_reg [2];

  assign pol_sig = {sel_v, filt_reg[0]};

  for (genvar j = 0; j < 2; j++)
  begin : g_pol
    // Over each period compare high and low time; counters saturate.
    always_ff @(posedge clock or negedge rst_n)
    begin
      if (!rst_n)
      begin
        pol_prev_reg[j] <= 1'b0;
        hi_cnt_reg[j]   <= '0;
        lo_cnt_reg[j]   <= '0;
        pol_reg[j]      <= 1'b1;
        pol_d_reg[j]    <= 1'b1;
      end
      else if (clk_en)
      begin
        pol_d_reg[j] <= pol_reg[j];
        if (osc_tick)
        begin
          pol_prev_reg[j] <= pol_sig[j];
          if (pol_sig[j] && !pol_prev_reg[j])
          begin
            pol_reg[j]    <= !(hi_cnt_reg[j] > lo_cnt_reg[j]); // R17
            hi_cnt_reg[j] <= '0;
            lo_cnt_reg[j] <= '0;
          end
          else if (pol_sig[j] && hi_cnt_reg[j] != '1) hi_cnt_reg[j] <= hi_cnt_reg[j] + 1'b1;
          else if (!pol_sig[j] && lo_cnt_reg[j] != '1) lo_cnt_reg[j] <= lo_cnt_reg[j] + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Horizontal period counter
  // ----------------------------------------------------------------
  logic [HORIZ_COUNT_LATCH_W-1:0] h_cnt_reg;     // Runs at half the time base.
  logic [5:0]        h_edge_reg;    // Periods in the current window.
  logic              v_load_reg;    // A vertical edge asks for a reload.
  logic              hf_ev_reg;     // One-cycle frequency event.
  logic              h_rise;
  logic              v_rise;

  assign h_rise = osc_tick && pol_sig[0] && !pol_prev_reg[0];
  assign v_rise = osc_tick && pol_sig[1] && !pol_prev_reg[1];

  // Counting at half rate makes the top 11 bits twice the period in ticks.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      h_cnt_reg         <= '0;
      h_edge_reg        <= 6'h00;
      v_load_reg        <= 1'b0;
      horiz_count_latch <= '0;
      horiz_overflow    <= 1'b0;
      hf_ev_reg         <= 1'b0;
    end
    else if (clk_en)
    begin
      hf_ev_reg <= 1'b0;
      if (v_rise) v_load_reg <= 1'b1;
      if (h_rise && h_edge_reg == H_WINDOW_LAST)
      begin
        h_cnt_reg      <= '0; // R5
        horiz_overflow <= (h_cnt_reg == '1); // R9
        if (h_cnt_reg == '1 && !horiz_overflow) hf_ev_reg <= 1'b1; // R10
        if (v_load_reg || !pres_reg[1])
        begin
          horiz_count_latch <= h_cnt_reg[HORIZ_COUNT_LATCH_W-1 -: HLATCH_W]; // R6 R11
          v_load_reg        <= 1'b0;
          if (h_cnt_reg[HORIZ_COUNT_LATCH_W-1 -: HLATCH_W] != horiz_count_latch) hf_ev_reg <= 1'b1; // R10
        end
      end
      else if (osc_tick && half_reg)
      begin
        if (h_cnt_reg != '1) h_cnt_reg <= h_cnt_reg + 1'b1;
        else if (!horiz_overflow)
        begin
          horiz_overflow <= 1'b1; // R9
          hf_ev_reg      <= 1'b1; // R10
        end
      end
      if (h_rise) h_edge_reg <= h_edge_reg + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Vertical period counter and blank protection
  // ----------------------------------------------------------------
  logic [VERT_COUNT_LATCH_W-1:0] v_cnt_reg;   // Counts in 16-tick units.
  logic [3:0]        v_pre_reg;   // Prescaler.
  logic              vf_ev_reg;   // One-cycle frequency event.
  logic              v_fast_reg;  // Vertical too fast for blanking.
  logic [VERT_COUNT_LATCH_W-1:0] vb_lim;

  assign vb_lim = presence_timebase_select ? VERT_COUNT_LATCH_W'(VB_FAST_P) : VERT_COUNT_LATCH_W'(VB_SLOW_P);

  // Each vertical edge latches the top 9 bits, i.e. period over 512 ticks.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      v_cnt_reg        <= '0;
      v_pre_reg        <= 4'h0;
      vert_count_latch <= '0;
      vert_overflow    <= 1'b0;
      vf_ev_reg        <= 1'b0;
      v_fast_reg       <= 1'b0;
    end
    else if (clk_en)
    begin
      vf_ev_reg <= 1'b0;
      if (v_rise)
      begin
        vert_count_latch <= v_cnt_reg[VERT_COUNT_LATCH_W-1 -: VLATCH_W]; // R7 R8 R11
        vert_overflow    <= (v_cnt_reg == '1); // R9
        if (v_cnt_reg == '1 && !vert_overflow) vf_ev_reg <= 1'b1; // R10
        v_fast_reg       <= (v_cnt_reg < vb_lim); // R19 R21
        if (v_cnt_reg[VERT_COUNT_LATCH_W-1 -: VLATCH_W] != vert_count_latch) vf_ev_reg <= 1'b1; // R10
        v_cnt_reg <= '0;
        v_pre_reg <= 4'h0;
      end
      else if (osc_tick)
      begin
        v_pre_reg <= v_pre_reg + 4'h1;
        if (v_cnt_reg >= vb_lim) v_fast_reg <= 1'b0;
        if (v_pre_reg == V_PRESCALE_LAST)
        begin
          if (v_cnt_reg != '1) v_cnt_reg <= v_cnt_reg + 1'b1;
          else if (!vert_overflow)
          begin
            vert_overflow <= 1'b1; // R9
            vf_ev_reg     <= 1'b1; // R10
          end
        end
      end
    end
  end

  // Blank output follows the selected vertical unless it runs too fast.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) vert_blank_out <= 1'b0;
    else if (clk_en) vert_blank_out <= sel_v && !v_fast_reg; // R19 R21
  end

  // ----------------------------------------------------------------
  // Event flags: a set in the same cycle as its clear wins
  // ----------------------------------------------------------------
  logic [5:0] flag_reg;
  logic [5:0] ev;
  logic       cv_chg;

  assign cv_chg = (pres_reg[2] != pres_d_reg[2]) && (sync_source_select != SRC_OFF); // R16
  assign ev[FLG_HPR] = pres_reg[0] != pres_d_reg[0]; // R15
  assign ev[FLG_VPR] = (pres_reg[1] != pres_d_reg[1]) || cv_chg; // R16
  assign ev[FLG_HPL] = pol_reg[0] != pol_d_reg[0]; // R18
  assign ev[FLG_VPL] = pol_reg[1] != pol_d_reg[1]; // R18
  assign ev[FLG_HF]  = hf_ev_reg;
  assign ev[FLG_VF]  = vf_ev_reg;

  // Flags stay until software clears them while serving the interrupt.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) flag_reg <= 6'h00;
    else if (clk_en) flag_reg <= (flag_reg & ~flag_clear) | ev; // R23
  end

  assign horiz_presence_change_flag = flag_reg[FLG_HPR];
  assign vert_presence_change_flag  = flag_reg[FLG_VPR];
  assign horiz_polarity_change_flag = flag_reg[FLG_HPL];
  assign vert_polarity_change_flag  = flag_reg[FLG_VPL];
  assign horiz_freq_change_flag     = flag_reg[FLG_HF];
  assign vert_freq_change_flag      = flag_reg[FLG_VF];
  assign composite_vert_present     = pres_reg[2];
  assign vert_present               = pres_reg[1];
  assign horiz_present              = pres_reg[0];
  assign horiz_polarity             = pol_reg[0];
  assign vert_polarity              = pol_reg[1];

endmodule // hvsp_top

`default_nettype wire

// [bench/hvsp_sync_src.sv]
// Video source model: periodic horizontal and vertical sync pulses.
// Assumes the bench gives periods and high times in system clock cycles.
`timescale 1ns/1ps
`default_nettype none
module hvsp_sync_src (
  input  wire logic        clock,
  input  wire logic        h_run,
  input  wire logic [15:0] h_period,
  input  wire logic [15:0] h_high,
  input  wire logic        v_run,
  input  wire logic [15:0] v_period,
  input  wire logic [15:0] v_high,
  output logic             hsync_in,
  output logic             vsync_in
);
  logic [15:0] h_pos_reg;  // Position inside the current line.
  logic [15:0] v_pos_reg;  // Position inside the current frame.
  // A stopped source parks at zero, so each burst starts with a fresh pulse.
  always_ff @(posedge clock)
  begin
    h_pos_reg <= (!h_run || h_pos_reg >= h_period - 16'h1) ? 16'h0 : h_pos_reg + 16'h1;
    v_pos_reg <= (!v_run || v_pos_reg >= v_period - 16'h1) ? 16'h0 : v_pos_reg + 16'h1;
  end
  // Pins idle low while switched off, as an unplugged cable with pull-down would.
  assign hsync_in = h_run && (h_pos_reg < h_high);
  assign vsync_in = v_run && (v_pos_reg < v_high);
endmodule // hvsp_sync_src
`default_nettype wire

// [bench/hvsp_checker_assertions.sv]
// Checker for the event flags of the sync processor.
// Assumes it is bound into hvsp_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module hvsp_checker
  import hvsp_pkg::*;
(
  input wire logic                clock, rst_b, clk_en, hsync_in, vsync_in,
  input wire logic [1:0]          sync_source_select,
  input wire logic                presence_timebase_select,
  input wire logic [5:0]          flag_clear,
  input wire logic                composite_vert_present, horiz_present, vert_present,
  input wire logic                horiz_polarity, vert_polarity, horiz_overflow, vert_overflow,
  input wire logic [HLATCH_W-1:0] horiz_count_latch,
  input wire logic [VLATCH_W-1:0] vert_count_latch,
  input wire logic                vert_blank_out, horiz_freq_change_flag, vert_freq_change_flag,
  input wire logic                horiz_presence_change_flag, vert_presence_change_flag,
  input wire logic                horiz_polarity_change_flag, vert_polarity_change_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // A status move seen at one edge must show as an event one cycle later.
  sequence s_hf_move;
    clk_en && ($changed(horiz_count_latch) || $rose(horiz_overflow));
  endsequence
  sequence s_vf_move;
    clk_en && ($changed(vert_count_latch) || $rose(vert_overflow));
  endsequence
  a_hpr_event_set: assert property (
    clk_en && $changed(horiz_present) |=> horiz_presence_change_flag)
    else $error("horizontal presence event missing");
  a_vpr_event_set: assert property (
    clk_en && ($changed(vert_present) || ($changed(composite_vert_present)
    && sync_source_select != SRC_OFF)) |=> vert_presence_change_flag)
    else $error("vertical presence event missing");
  a_hpl_event_set: assert property (
    clk_en && $changed(horiz_polarity) |=> horiz_polarity_change_flag)
    else $error("horizontal polarity event missing");
  a_vpl_event_set: assert property (
    clk_en && $changed(vert_polarity) |=> vert_polarity_change_flag)
    else $error("vertical polarity event missing");
  a_hf_event_set: assert property (s_hf_move |=> horiz_freq_change_flag)
    else $error("horizontal frequency event missing");
  a_vf_event_set: assert property (s_vf_move |=> vert_freq_change_flag)
    else $error("vertical frequency event missing");
  a_hpr_clear_works: assert property (
    clk_en && flag_clear[FLG_HPR] && $stable(horiz_present) |=> !horiz_presence_change_flag)
    else $error("horizontal presence event not cleared");
  a_hpl_flag_sticky: assert property (
    horiz_polarity_change_flag && !flag_clear[FLG_HPL] |=> horiz_polarity_change_flag)
    else $error("horizontal polarity event dropped");
  a_hf_clear_works: assert property (
    clk_en && flag_clear[FLG_HF] && $stable(horiz_count_latch) && $stable(horiz_overflow)
    |=> !horiz_freq_change_flag)
    else $error("horizontal frequency event not cleared");
endmodule // hvsp_checker
bind hvsp_top hvsp_checker i_chk (.*);
`default_nettype wire

// [bench/tb.sv]
// Bench for the sync processor: drives a source model and judges counts and flags.
// Assumes the package, the design top, the source model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hvsp_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic [1:0] sync_source_select = SRC_VIN;
  logic presence_timebase_select = 1'b0;
  logic [5:0] flag_clear = 6'h00;
  logic h_run = 1'b0;
  logic v_run = 1'b0;
  logic [15:0] h_period = 16'h7d, h_high = 16'h28, v_period = 16'h0fa0, v_high = 16'h5;
  logic hsync_in, vsync_in, composite_vert_present, horiz_present, vert_present;
  logic horiz_polarity, vert_polarity, horiz_overflow, vert_overflow, vert_blank_out;
  logic [HLATCH_W-1:0] horiz_count_latch;
  logic [VLATCH_W-1:0] vert_count_latch;
  logic horiz_presence_change_flag, vert_presence_change_flag, horiz_polarity_change_flag;
  logic vert_polarity_change_flag, horiz_freq_change_flag, vert_freq_change_flag;
  int n_fail = 0;
  int tests_run = 0;
  always #4 clock = ~clock;
  // Short fast-base limits keep the run small; the drop limit stays above the set limit.
  hvsp_top #(.V_SET_FAST_P(1200), .CLR_FAST_P(1500), .VB_SLOW_P(10),
    .VB_FAST_P(10)) i_dut (.*);
  hvsp_sync_src i_src (.*);
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Counts may sit one step either side of the ideal value.
  task automatic near(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check(what, (seen === exp || seen === exp + 16'h1 || seen === exp - 16'h1) ? exp : seen, exp);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic clear_flags(input logic [5:0] which);
    flag_clear <= which;
    @(posedge clock);
    flag_clear <= 6'h00;
    cycles(2);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_reset();
    check("polarities", {horiz_polarity, vert_polarity}, 2'h3);
    check("presence", {composite_vert_present, horiz_present, vert_present}, 3'h0);
  endtask
  // A 1 us line gives twice 8 or 12 ticks; vertical pin carries only glitches.
  task automatic t_hline();
    h_run <= 1'b1;
    v_run <= 1'b1;
    cycles(18000);
    check("h present", horiz_present, 1'b1);
    check("h polarity", horiz_polarity, 1'b1);
    near("h count slow", horiz_count_latch, 16'h10);
    check("v glitch", vert_present, 1'b0);
    check("cv present", composite_vert_present, 1'b0);
    check("h events", {horiz_presence_change_flag, horiz_freq_change_flag}, 2'h3);
    clear_flags(6'h22);
    check("h cleared", {horiz_presence_change_flag, horiz_freq_change_flag}, 2'h0);
    presence_timebase_select <= 1'b1;
    cycles(18000);
    near("h count fast", horiz_count_latch, 16'h18);
    check("h freq event", horiz_freq_change_flag, 1'b1);
  endtask
  task automatic t_hpol();
    h_high <= 16'h55;
    cycles(2000);
    check("h polarity neg", horiz_polarity, 1'b0);
    check("h pol event", horiz_polarity_change_flag, 1'b1);
  endtask
  // A 64 us frame is 768 fast ticks, one and a half steps of 512.
  task automatic t_vframe();
    v_period <= 16'h1f40;
    v_high <= 16'h12c;
    cycles(30000);
    check("v present", vert_present, 1'b1);
    near("v count", vert_count_latch, 16'h1);
    check("v polarity", vert_polarity, 1'b1);
    check("v events", {vert_presence_change_flag, vert_freq_change_flag}, 2'h3);
    near("h count framed", horiz_count_latch, 16'h18);
    check("overflows", {horiz_overflow, vert_overflow}, 2'h0);
    clear_flags(6'h10);
    check("v cleared", vert_presence_change_flag, 1'b0);
  endtask
  task automatic t_loss();
    h_run <= 1'b0;
    v_run <= 1'b0;
    cycles(20000);
    check("h lost", horiz_present, 1'b0);
    check("v lost", vert_present, 1'b0);
    check("blank idle", vert_blank_out, 1'b0);
    check("loss events", {horiz_presence_change_flag, vert_presence_change_flag}, 2'h3);
  endtask
  initial
  begin
    cycles(99000);
    n_fail++;
    close_out();
  end
  initial
  begin
    cycles(6);
    rst_b <= 1'b1;
    cycles(4);
    t_reset();
    t_hline();
    t_hpol();
    t_vframe();
    t_loss();
    close_out();
  end
endmodule // tb
`default_nettype wire
